// *** core/gpv_pkg.sv ***
// Package: register map, field layouts and state type of the I/O port block
package gpv_pkg;

  localparam int GPV_PORTS = 3;
  localparam int GPV_PIN_W = 48;
  localparam int GPV_DW = 16;
  localparam int GPV_AW = 16;

  // Word-port register offsets (byte addresses, even = low byte port)
  localparam logic [15:0] GPV_PA_IN = 16'h0010;
  localparam logic [15:0] GPV_PA_OUT = 16'h0012;
  localparam logic [15:0] GPV_PA_DIR = 16'h0014;
  localparam logic [15:0] GPV_PA_SEL0 = 16'h001A;
  localparam logic [15:0] GPV_PA_SEL1 = 16'h001C;
  localparam logic [15:0] GPV_PA_IES = 16'h0028;
  localparam logic [15:0] GPV_PA_IE = 16'h002A;
  localparam logic [15:0] GPV_PA_IFG = 16'h002C;
  localparam logic [15:0] GPV_PB_IN = 16'h0030;
  localparam logic [15:0] GPV_PB_OUT = 16'h0032;
  localparam logic [15:0] GPV_PB_DIR = 16'h0034;
  localparam logic [15:0] GPV_PB_SEL0 = 16'h003A;
  localparam logic [15:0] GPV_PB_SEL1 = 16'h003C;
  localparam logic [15:0] GPV_PC_IN = 16'h0040;
  localparam logic [15:0] GPV_PC_OUT = 16'h0042;
  localparam logic [15:0] GPV_PC_DIR = 16'h0044;
  localparam logic [15:0] GPV_PC_SEL0 = 16'h004A;
  localparam logic [15:0] GPV_PC_SEL1 = 16'h004C;
  localparam logic [15:0] GPV_P1_VEC = 16'h001E;
  localparam logic [15:0] GPV_P2_VEC = 16'h002E;
  localparam logic [15:0] GPV_IRQ_STS = 16'h0050;
  localparam logic [15:0] GPV_IRQ_CLR = 16'h0052;
  localparam logic [15:0] GPV_IRQ_EN = 16'h0054;

  localparam logic [2:0][15:0] GPV_IN_OFS = {GPV_PC_IN, GPV_PB_IN, GPV_PA_IN};
  localparam logic [2:0][15:0] GPV_OUT_OFS =
    {GPV_PC_OUT, GPV_PB_OUT, GPV_PA_OUT};
  localparam logic [2:0][15:0] GPV_DIR_OFS =
    {GPV_PC_DIR, GPV_PB_DIR, GPV_PA_DIR};
  localparam logic [2:0][15:0] GPV_SEL0_OFS =
    {GPV_PC_SEL0, GPV_PB_SEL0, GPV_PA_SEL0};
  localparam logic [2:0][15:0] GPV_SEL1_OFS =
    {GPV_PC_SEL1, GPV_PB_SEL1, GPV_PA_SEL1};

  // Reset values and lane masks
  localparam logic [15:0] GPV_RST_WORD = 16'h0000;
  localparam logic [15:0] GPV_VEC_NONE = 16'h0000;
  localparam logic [15:0] GPV_MASK_LO = 16'h00FF;
  localparam logic [15:0] GPV_MASK_HI = 16'hFF00;
  localparam logic [15:0] GPV_MASK_ALL = 16'hFFFF;

  typedef struct packed {
    logic primed;
    logic [2:0][15:0] pin_in;
    logic [15:0] prev_a;
    logic [2:0][15:0] out;
    logic [2:0][15:0] dir;
    logic [2:0][15:0] sel0;
    logic [2:0][15:0] sel1;
    logic [15:0] ies;
    logic [15:0] ie;
    logic [15:0] ifg;
    logic [1:0] irq_sts;
    logic [1:0] irq_en;
    logic irq;
    logic [15:0] rdata;
  } gpv_state_type;

endpackage

// *** core/gpv_top.sv ***
// Digital I/O port registers with pin-interrupt flags and vector registers
//
// Contract
// - Vector reads zero when no flag pending.
// - Flag n reported as vector code 2n+2.
// - Lowest-numbered pending pin wins the vector.
// - Vector only bits 4..1 nonzero, read-only.
// - Vector, dir, selects, enable, flags reset zero.
// - Word registers reachable as word or bytes.
// - Input registers read-only, writes ignored.
// - Low byte even port, high byte odd.
// - Edge select 0 rising, 1 falling.
// - Enable bit one passes pin interrupt request.
// - Flag one means pending, zero none.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module gpv_top (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [gpv_pkg::GPV_AW-1:0] bus_addr_i,
  input wire logic [gpv_pkg::GPV_DW-1:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic bus_byte_i,
  output logic [gpv_pkg::GPV_DW-1:0] bus_rdata_o,
  input wire logic [gpv_pkg::GPV_PIN_W-1:0] pin_in_i,
  output logic [gpv_pkg::GPV_PIN_W-1:0] pin_out_o,
  output logic [gpv_pkg::GPV_PIN_W-1:0] pin_dir_o,
  output logic [gpv_pkg::GPV_PIN_W-1:0] pin_sel0_o,
  output logic [gpv_pkg::GPV_PIN_W-1:0] pin_sel1_o,
  output logic irq_o
);
  import gpv_pkg::*;

  logic rst_meta_reg;
  logic rst_sync_b_reg;
  gpv_state_type st_reg;
  gpv_state_type st_next;
  logic [15:0] wmask;
  logic [15:0] wdat;
  logic [15:0] rise;
  logic [15:0] fall;
  logic [15:0] edge_set;
  logic [15:0] flag_wr;
  logic [15:0] vec_clr;
  logic [15:0] rword;
  logic [15:0] code1;
  logic [15:0] code2;
  logic [7:0] pick1;
  logic [7:0] pick2;
  logic [1:0] evt;
  logic clr_lane_ok;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    return a[15:1] == ofs[15:1];
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] m,
                                        input logic [15:0] d);
    return (old & ~m) | (d & m);
  endfunction

  // Reset release through two flops
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_b_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_b_reg <= rst_meta_reg;
    end
  end

  // One instance per byte port with interrupt capability
  gpv_vector #(.WIDTH(8)) u_vec1 (
    .flags_i(st_reg.ifg[7:0]),
    .code_o(code1),
    .pick_o(pick1)
  );

  gpv_vector #(.WIDTH(8)) u_vec2 (
    .flags_i(st_reg.ifg[15:8]),
    .code_o(code2),
    .pick_o(pick2)
  );

  // Byte access: odd address is the high lane, data rides in the low byte
  always_comb begin
    if (bus_byte_i) begin
      wmask = bus_addr_i[0] ? GPV_MASK_HI : GPV_MASK_LO;
      wdat = {bus_wdata_i[7:0], bus_wdata_i[7:0]};
    end else begin
      wmask = GPV_MASK_ALL;
      wdat = bus_wdata_i;
    end
  end

  // Pin edges on the sampled port A inputs
  always_comb begin
    rise = st_reg.pin_in[0] & ~st_reg.prev_a;
    fall = ~st_reg.pin_in[0] & st_reg.prev_a;
    edge_set = st_reg.primed ?
      ((st_reg.ies & fall) | (~st_reg.ies & rise)) : '0;
    evt[0] = |(edge_set[7:0] & st_reg.ie[7:0]);
    evt[1] = |(edge_set[15:8] & st_reg.ie[15:8]);
  end

  // Read mux, and the flag that a vector read retires
  always_comb begin
    rword = '0;
    vec_clr = '0;
    clr_lane_ok = !(bus_byte_i && bus_addr_i[0]);
    if (bus_rd_i) begin
      for (int p = 0; p < GPV_PORTS; p++) begin
        if (hit(bus_addr_i, GPV_IN_OFS[p])) rword = st_reg.pin_in[p];
        if (hit(bus_addr_i, GPV_OUT_OFS[p])) rword = st_reg.out[p];
        if (hit(bus_addr_i, GPV_DIR_OFS[p])) rword = st_reg.dir[p];
        if (hit(bus_addr_i, GPV_SEL0_OFS[p])) rword = st_reg.sel0[p];
        if (hit(bus_addr_i, GPV_SEL1_OFS[p])) rword = st_reg.sel1[p];
      end
      if (hit(bus_addr_i, GPV_PA_IES)) rword = st_reg.ies;
      if (hit(bus_addr_i, GPV_PA_IE)) rword = st_reg.ie;
      if (hit(bus_addr_i, GPV_PA_IFG)) rword = st_reg.ifg;
      if (hit(bus_addr_i, GPV_IRQ_STS)) rword = {14'h0000, st_reg.irq_sts};
      if (hit(bus_addr_i, GPV_IRQ_EN)) rword = {14'h0000, st_reg.irq_en};
      if (hit(bus_addr_i, GPV_P1_VEC)) begin
        rword = code1;
        if (clr_lane_ok) vec_clr[7:0] = pick1;
      end
      if (hit(bus_addr_i, GPV_P2_VEC)) begin
        rword = code2;
        if (clr_lane_ok) vec_clr[15:8] = pick2;
      end
    end
  end

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.primed = 1'b1;
    st_next.pin_in = pin_in_i;
    // First sample after reset seeds both stages, so no false edge
    st_next.prev_a = st_reg.primed ? st_reg.pin_in[0] : pin_in_i[15:0];
    flag_wr = st_reg.ifg;
    if (bus_wr_i) begin
      // Input registers have no write path at all
      for (int p = 0; p < GPV_PORTS; p++) begin
        if (hit(bus_addr_i, GPV_OUT_OFS[p])) begin
          st_next.out[p] = merge(st_reg.out[p], wmask, wdat);
        end
        if (hit(bus_addr_i, GPV_DIR_OFS[p])) begin
          st_next.dir[p] = merge(st_reg.dir[p], wmask, wdat);
        end
        if (hit(bus_addr_i, GPV_SEL0_OFS[p])) begin
          st_next.sel0[p] = merge(st_reg.sel0[p], wmask, wdat);
        end
        if (hit(bus_addr_i, GPV_SEL1_OFS[p])) begin
          st_next.sel1[p] = merge(st_reg.sel1[p], wmask, wdat);
        end
      end
      if (hit(bus_addr_i, GPV_PA_IES)) begin
        st_next.ies = merge(st_reg.ies, wmask, wdat);
      end
      if (hit(bus_addr_i, GPV_PA_IE)) begin
        st_next.ie = merge(st_reg.ie, wmask, wdat);
      end
      if (hit(bus_addr_i, GPV_PA_IFG)) begin
        flag_wr = merge(st_reg.ifg, wmask, wdat);
      end
      if (hit(bus_addr_i, GPV_IRQ_EN) && !(bus_byte_i && bus_addr_i[0])) begin
        st_next.irq_en = wdat[1:0];
      end
    end
    // A new edge wins over a software or vector-read clear
    st_next.ifg = (flag_wr & ~vec_clr) | edge_set;
    if (bus_wr_i && hit(bus_addr_i, GPV_IRQ_CLR) &&
        !(bus_byte_i && bus_addr_i[0])) begin
      st_next.irq_sts = (st_reg.irq_sts & ~wdat[1:0]) | evt;
    end else begin
      st_next.irq_sts = st_reg.irq_sts | evt;
    end
    st_next.irq = |(st_next.irq_sts & st_next.irq_en);
    if (bus_byte_i) begin
      st_next.rdata = {8'h00, bus_addr_i[0] ? rword[15:8] : rword[7:0]};
    end else begin
      st_next.rdata = rword;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata_o = st_reg.rdata;
  assign pin_out_o = st_reg.out;
  assign pin_dir_o = st_reg.dir;
  assign pin_sel0_o = st_reg.sel0;
  assign pin_sel1_o = st_reg.sel1;
  assign irq_o = st_reg.irq;

  // Checks
  logic rd_v1;
  logic wr_lo_cln;
  logic rd_v2;
  logic rd_hi1;
  assign rd_v1 = bus_rd_i && !bus_byte_i && hit(bus_addr_i, GPV_P1_VEC);
  assign wr_lo_cln = !bus_wr_i && edge_set == '0;
  assign rd_v2 = bus_rd_i && !bus_byte_i && hit(bus_addr_i, GPV_P2_VEC);
  assign rd_hi1 = bus_rd_i && bus_byte_i &&
    bus_addr_i == (GPV_P1_VEC | 16'h0001);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_sync_b_reg);

  a_vec_empty:
    assert property (rd_v1 && st_reg.ifg[7:0] == 8'h00 |=>
      bus_rdata_o == 16'h0000)
    else $error("vector not zero with no flag pending");

  a_vec_lowest:
    assert property (rd_v1 && st_reg.ifg[7:0] == 8'h80 |=>
      bus_rdata_o == 16'h0010)
    else $error("vector code for pin 7 wrong");

  a_vec_priority:
    assert property (rd_v1 && st_reg.ifg[0] |=> bus_rdata_o == 16'h0002)
    else $error("pin 0 not given top priority");

  a_vec_fields:
    assert property (rd_v1 |=> bus_rdata_o[0] == 1'b0 &&
      bus_rdata_o[15:5] == 11'h000)
    else $error("vector reserved bits set");

  a_reset_zero:
    assert property ($rose(rst_sync_b_reg) |-> st_reg.dir == '0 &&
      st_reg.ie == '0 && st_reg.ifg == '0 && st_reg.sel0 == '0)
    else $error("state not cleared by reset");

  a_byte_lane:
    assert property (bus_wr_i && bus_byte_i &&
      bus_addr_i == (GPV_PA_DIR | 16'h0001) |=>
      st_reg.dir[0][7:0] == $past(st_reg.dir[0][7:0]) &&
      st_reg.dir[0][15:8] == $past(bus_wdata_i[7:0]))
    else $error("odd byte write hit wrong lane");

  a_input_ro:
    assert property (bus_wr_i && hit(bus_addr_i, GPV_PA_IN) |=>
      st_reg.pin_in[0] == $past(pin_in_i[15:0]))
    else $error("input register took a write");

  a_edge_rise:
    assert property (st_reg.primed && !st_reg.ies[0] &&
      st_reg.pin_in[0][0] && !st_reg.prev_a[0] |=> st_reg.ifg[0])
    else $error("rising edge did not set flag");

  a_irq_enable:
    assert property (edge_set[0] && st_reg.ie[0] |=> st_reg.irq_sts[0])
    else $error("enabled pin edge did not raise status");

  a_irq_level:
    assert property (st_reg.irq_sts == 2'b00 |-> !irq_o)
    else $error("interrupt high with no status");

  a_flag_read:
    assert property (bus_rd_i && !bus_byte_i &&
      hit(bus_addr_i, GPV_PA_IFG) |=> bus_rdata_o == $past(st_reg.ifg))
    else $error("flag read back wrong");

  a_vec_retire:
    assert property (rd_v1 && st_reg.ifg[1:0] == 2'b11 && wr_lo_cln |=>
      !st_reg.ifg[0] && st_reg.ifg[1] ##1 1'b1)
    else $error("vector read did not retire reported flag");

  // Second byte port vector
  a_vec_port2:
    assert property (rd_v2 && st_reg.ifg[15:8] == 8'h01 |=>
      bus_rdata_o == 16'h0002)
    else $error("second port vector code for pin 0 wrong");

  a_vec_next_pin:
    assert property (rd_v2 && !st_reg.ifg[8] && st_reg.ifg[9] |=>
      bus_rdata_o == 16'h0004)
    else $error("second port vector skipped pin 1");

  // The odd byte of a vector is always zero and retires nothing
  a_vec_odd_byte:
    assert property (rd_hi1 |=> bus_rdata_o == 16'h0000)
    else $error("vector high byte not zero");

  a_odd_keeps_flag:
    assert property (rd_hi1 && wr_lo_cln |=>
      st_reg.ifg == $past(st_reg.ifg))
    else $error("odd byte vector read cleared a flag");

  a_reset_rest:
    assert property ($rose(rst_sync_b_reg) |-> st_reg.sel1 == '0 &&
      st_reg.irq_sts == 2'b00 && st_reg.irq_en == 2'b00 && !irq_o)
    else $error("selects or interrupt state not cleared by reset");

  a_word_write:
    assert property (bus_wr_i && !bus_byte_i && hit(bus_addr_i, GPV_PA_OUT)
      |=> st_reg.out[0] == $past(bus_wdata_i))
    else $error("word write did not land whole");

  a_ies_high:
    assert property (bus_wr_i && bus_byte_i &&
      bus_addr_i == (GPV_PA_IES | 16'h0001) |=>
      st_reg.ies[15:8] == $past(bus_wdata_i[7:0]) &&
      st_reg.ies[7:0] == $past(st_reg.ies[7:0]))
    else $error("odd byte edge select write hit wrong lane");

  a_edge_fall:
    assert property (st_reg.primed && st_reg.ies[0] &&
      !st_reg.pin_in[0][0] && st_reg.prev_a[0] |=> st_reg.ifg[0])
    else $error("falling edge did not set flag");

  a_no_false_edge:
    assert property ($rose(rst_sync_b_reg) |=> edge_set == '0)
    else $error("edge seen in first cycle after reset");

  a_irq_refused:
    assert property (!st_reg.irq_sts[0] &&
      (edge_set[7:0] & st_reg.ie[7:0]) == 8'h00 |=> !st_reg.irq_sts[0])
    else $error("status raised without an enabled edge");

  a_irq_port2:
    assert property (edge_set[8] && st_reg.ie[8] |=> st_reg.irq_sts[1])
    else $error("enabled high-lane edge did not raise status");

  a_set_wins:
    assert property (edge_set[0] && bus_wr_i && !bus_byte_i &&
      hit(bus_addr_i, GPV_PA_IFG) |=> st_reg.ifg[0])
    else $error("flag write cleared a flag set by an edge");

  c_two_pending: cover property (rd_v1 && st_reg.ifg[2:1] == 2'b11);
  c_irq_rise: cover property ($rose(irq_o));
  c_odd_byte: cover property (bus_wr_i && bus_byte_i && bus_addr_i[0]);
  c_fall_edge: cover property (edge_set[0] && st_reg.ies[0]);
  c_port2_vec: cover property (rd_v2 && st_reg.ifg[15:8] != 8'h00);

endmodule
`default_nettype wire

// *** core/gpv_vector.sv ***
// Priority encoder turning one byte port's pin flags into its vector code
`timescale 1ns/1ps
`default_nettype none
module gpv_vector #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] flags_i,
  output logic [gpv_pkg::GPV_DW-1:0] code_o,
  output logic [WIDTH-1:0] pick_o
);
  import gpv_pkg::*;

  // Scan from the top down so the lowest pending pin is the one left
  always_comb begin
    code_o = GPV_VEC_NONE;
    pick_o = '0;
    for (int n = WIDTH - 1; n >= 0; n--) begin
      if (flags_i[n]) begin
        code_o = 16'((n + 1) * 2);
        pick_o = '0;
        pick_o[n] = 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// *** dv/gpv_pin_model.sv ***
// Model of the external pins that sit on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module gpv_pin_model (
  input wire logic [gpv_pkg::GPV_PIN_W-1:0] lvl_i,
  input wire logic [gpv_pkg::GPV_PIN_W-1:0] drv_i,
  input wire logic [gpv_pkg::GPV_PIN_W-1:0] dir_i,
  output logic [gpv_pkg::GPV_PIN_W-1:0] pin_o
);
  import gpv_pkg::*;
  // A pin the port drives reads back its own level, others the outside one
  assign pin_o = (dir_i & drv_i) | (~dir_i & lvl_i);
endmodule
`default_nettype wire

// *** dv/gpv_top_test.sv ***
// Self-checking bench for the port registers and pin-interrupt vectors
`timescale 1ns/1ps
`default_nettype none
module gpv_top_test;
  import gpv_pkg::*;
  logic mclk_i, rst_b_i, bus_wr_i, bus_rd_i, bus_byte_i, irq_o;
  logic [15:0] bus_addr_i, bus_wdata_i, bus_rdata_o;
  logic [47:0] lvl, pin_in, pin_out, pin_dir, pin_sel0, pin_sel1;
  logic [15:0] zr [9] = '{16'h0014, 16'h001A, 16'h001C, 16'h002A,
    16'h002C, 16'h001E, 16'h0034, 16'h0044, 16'h004C};
  int bad_count;
  int samples_checked;

  gpv_top dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_byte_i(bus_byte_i), .bus_rdata_o(bus_rdata_o), .pin_in_i(pin_in),
    .pin_out_o(pin_out), .pin_dir_o(pin_dir), .pin_sel0_o(pin_sel0),
    .pin_sel1_o(pin_sel1), .irq_o(irq_o));
  gpv_pin_model pins (.lvl_i(lvl), .drv_i(pin_out), .dir_i(pin_dir),
    .pin_o(pin_in));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] v,
                    input logic b);
    @(posedge mclk_i);
    bus_addr_i <= a;
    bus_wdata_i <= v;
    bus_byte_i <= b;
    bus_wr_i <= 1'b1;
    @(posedge mclk_i);
    bus_wr_i <= 1'b0;
  endtask

  // Read strobe for one cycle, data checked in the following cycle only
  task automatic rdc(input logic [15:0] a, input logic b,
                     input logic [15:0] exp);
    @(posedge mclk_i);
    bus_addr_i <= a;
    bus_byte_i <= b;
    bus_rd_i <= 1'b1;
    @(posedge mclk_i);
    bus_rd_i <= 1'b0;
    #1;
    chk(bus_rdata_o, exp);
  endtask

  task automatic pins_to(input logic [15:0] v);
    @(posedge mclk_i);
    lvl[15:0] <= v;
    repeat (3) @(posedge mclk_i);
  endtask

  initial begin
    #200000;
    bad_count++;
    complete_run();
  end

  initial begin
    rst_b_i = 1'b0;
    bus_wr_i = 1'b0;
    bus_rd_i = 1'b0;
    bus_byte_i = 1'b0;
    bus_addr_i = 16'h0000;
    bus_wdata_i = 16'h0000;
    lvl = 48'h0000_0000_0000;
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    foreach (zr[i]) rdc(zr[i], 1'b0, 16'h0000);
    chk(pin_dir[15:0], 16'h0000);
    // Input register follows the pins and ignores writes
    @(posedge mclk_i);
    lvl[31:16] <= 16'h5A5A;
    wr(GPV_PB_IN, 16'hFFFF, 1'b0);
    rdc(GPV_PB_IN, 1'b0, 16'h5A5A);
    rdc(GPV_PB_OUT, 1'b0, 16'h0000);
    // Word and byte views of one register
    wr(GPV_PA_OUT, 16'h1234, 1'b0);
    rdc(GPV_PA_OUT, 1'b1, 16'h0034);
    rdc(16'h0013, 1'b1, 16'h0012);
    wr(16'h0013, 16'h00AB, 1'b1);
    rdc(GPV_PA_OUT, 1'b0, 16'hAB34);
    chk(pin_out[15:0], 16'hAB34);
    for (int p = 0; p < 3; p++) begin
      wr(GPV_SEL1_OFS[p], 16'hA5C3 ^ 16'(p), 1'b0);
      rdc(GPV_SEL1_OFS[p], 1'b0, 16'hA5C3 ^ 16'(p));
    end
    chk(pin_sel1[47:32], 16'hA5C1);
    wr(GPV_PB_SEL0, 16'h3C5A, 1'b0);
    #1;
    chk(pin_sel0[31:16], 16'h3C5A);
    chk(pin_sel0[15:0], 16'h0000);
    // Vector codes in priority order, each word read clearing its flag, the odd-byte read none
    wr(GPV_P1_VEC, 16'hFFFF, 1'b0);
    rdc(GPV_P1_VEC, 1'b0, 16'h0000);
    wr(GPV_PA_IFG, 16'h81FF, 1'b0);
    for (int n = 0; n < 8; n++) begin
      rdc(GPV_P1_VEC, 1'b0, 16'(2 * n + 2));
    end
    rdc(GPV_P1_VEC, 1'b0, 16'h0000);
    rdc(GPV_P2_VEC, 1'b0, 16'h0002);
    rdc(16'h002F, 1'b1, 16'h0000);
    rdc(GPV_P2_VEC, 1'b0, 16'h0010);
    rdc(GPV_P2_VEC, 1'b0, 16'h0000);
    // Pin edges raise flags and the interrupt
    wr(GPV_IRQ_EN, 16'h0001, 1'b0);
    wr(GPV_PA_IE, 16'h0001, 1'b0);
    pins_to(16'h0009);
    rdc(GPV_PA_IFG, 1'b0, 16'h0009);
    chk(16'(irq_o), 16'h0001);
    rdc(GPV_IRQ_STS, 1'b0, 16'h0001);
    wr(GPV_PA_IFG, 16'h0000, 1'b0);
    wr(GPV_IRQ_CLR, 16'h0001, 1'b0);
    #1;
    chk(16'(irq_o), 16'h0000);
    wr(GPV_PA_IES, 16'h00FF, 1'b0);
    rdc(GPV_PA_IFG, 1'b0, 16'h0000);
    pins_to(16'h0000);
    rdc(GPV_PA_IFG, 1'b0, 16'h0009);
    chk(16'(irq_o), 16'h0001);
    wr(GPV_IRQ_EN, 16'h0000, 1'b0);
    #1;
    chk(16'(irq_o), 16'h0000);
    // Only the enabled high-lane pin raises its status bit
    wr(GPV_PA_IES, 16'h0000, 1'b0);
    wr(GPV_PA_IFG, 16'h0000, 1'b0);
    wr(GPV_PA_IE, 16'h0100, 1'b0);
    wr(GPV_IRQ_CLR, 16'h0003, 1'b0);
    wr(GPV_IRQ_EN, 16'h0003, 1'b0);
    #1;
    chk(16'(irq_o), 16'h0000);
    pins_to(16'h0102);
    rdc(GPV_PA_IFG, 1'b0, 16'h0102);
    rdc(GPV_IRQ_STS, 1'b0, 16'h0002);
    chk(16'(irq_o), 16'h0001);
    rdc(GPV_P1_VEC, 1'b0, 16'h0004);
    rdc(GPV_P2_VEC, 1'b0, 16'h0002);
    rdc(GPV_PA_IFG, 1'b0, 16'h0000);
    // Reset in mid-run clears the registers again, with no false edge
    wr(GPV_PB_DIR, 16'h00FF, 1'b0);
    rdc(GPV_PB_DIR, 1'b0, 16'h00FF);
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rdc(GPV_PA_IFG, 1'b0, 16'h0000);
    chk(pin_dir[31:16], 16'h0000);
    chk(16'(irq_o), 16'h0000);
    rdc(GPV_PA_IE, 1'b0, 16'h0000);
    rdc(GPV_IRQ_EN, 1'b0, 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
